/* core/gic_pkg.sv */
// Shared constants, register map and carrier types for the pin interrupt block
package gic_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int PIN_COUNT = 32;          // Pins served by the block
  localparam int HALF_W = 16;             // Width of each half register
  localparam int AXI_ADDR_W = 12;         // Register bus address width
  localparam int AXI_DATA_W = 32;         // Register bus data width
  localparam int IDX_LSB = 2;             // Word index starts here
  localparam int IDX_W = AXI_ADDR_W - IDX_LSB; // Decoded index bits
  localparam int SYNC_STAGES = 2;         // Pin synchroniser depth
  localparam int CARRIER_PIN = 15;        // Pin fixed to carrier detect

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [31:0] IDX_LO_PENDING = 32'h0B00_0108; // Status low
  localparam logic [31:0] IDX_HI_PENDING = 32'h0B00_010A; // Status high
  localparam logic [31:0] IDX_LO_ALLOW = 32'h0B00_010C;   // Enable low
  localparam logic [31:0] IDX_HI_ALLOW = 32'h0B00_010E;   // Enable high
  localparam logic [31:0] IDX_LO_TRIG = 32'h0B00_0110;    // Trigger low
  localparam logic [31:0] IDX_HI_TRIG = 32'h0B00_0112;    // Trigger high
  localparam logic [31:0] IDX_LO_LEVEL = 32'h0B00_0114;   // Level low
  localparam logic [31:0] IDX_HI_LEVEL = 32'h0B00_0116;   // Level high
  localparam logic [31:0] IDX_LO_CLEAR = 32'h0B00_011C;   // Clear low
  localparam logic [31:0] IDX_HI_CLEAR = 32'h0B00_011E;   // Clear high

  // ****************************************************************
  // Reset values and encodings
  // ****************************************************************
  localparam logic [15:0] HALF_RESET = 16'h0000;   // All config halves
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000; // Zero word
  localparam logic [1:0] RESP_OKAY = 2'h0;         // Bus answer good
  localparam logic [1:0] RESP_SLVERR = 2'h2;       // Bus answer error
  localparam logic TRIG_EDGE = 1'b1;               // Trigger bit: edge
  localparam logic LEVEL_HIGH = 1'b1;              // Level bit: high

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  // Per-pin interrupt configuration
  typedef struct packed {
    logic [PIN_COUNT-1:0] allow;   // Enable per pin
    logic [PIN_COUNT-1:0] trigger; // 1 edge, 0 level
    logic [PIN_COUNT-1:0] level;   // 1 high, 0 low
  } gic_cfg_type;

  // Write request held between address and data phases
  typedef struct packed {
    logic [IDX_W-1:0] idx;         // Word index
    logic [AXI_DATA_W-1:0] data;   // Write data
    logic [3:0] strb;              // Byte lanes
  } gic_wreq_type;

endpackage : gic_pkg

/* core/gic_pin_detect.sv */
// Pin synchroniser and per-pin trigger evaluation
`timescale 1ns/1ps
module gic_pin_detect
  import gic_pkg::*;
#(
  parameter int WIDTH = PIN_COUNT  // Number of pins
)
(
  input wire logic aclk,                  // System clock
  input wire logic aresetn,               // Synchronous reset, low
  input wire logic [WIDTH-1:0] pin_in,    // Asynchronous pin levels
  input wire logic [WIDTH-1:0] trigger,   // 1 edge, 0 level
  input wire logic [WIDTH-1:0] level,     // 1 high, 0 low
  output logic [WIDTH-1:0] sync_level,    // Synchronised pin level
  output logic [WIDTH-1:0] prev_level,    // Level one cycle earlier
  output logic [WIDTH-1:0] match          // Pin meets its trigger
);

  // Width check
  if (WIDTH < 1)
  begin : g_bad_width
    $error("gic_pin_detect: WIDTH must be at least one");
  end

  // ****************************************************************
  // Per-pin synchroniser and evaluation
  // ****************************************************************
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_pin
    logic meta_reg;   // First stage, read only by second
    logic sync_reg;   // Second stage
    logic prev_reg;   // Previous synchronised level
    logic meta_next;  // Next first stage
    logic sync_next;  // Next second stage
    logic prev_next;  // Next previous level

    // Next values of the chain
    always_comb
    begin
      meta_next = pin_in[i];
      sync_next = meta_reg;
      prev_next = sync_reg;
    end

    // Two flops before any logic looks at the pin
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        meta_reg <= 1'b0;
        sync_reg <= 1'b0;
        prev_reg <= 1'b0;
      end
      else
      begin
        meta_reg <= meta_next;
        sync_reg <= sync_next;
        prev_reg <= prev_next;
      end
    end

    assign sync_level[i] = sync_reg;
    assign prev_level[i] = prev_reg;
    // Edge: any change; level: compare to chosen level
    // Level bit plays no part in edge mode
    assign match[i] = (trigger[i] == TRIG_EDGE) ?
                      (sync_reg ^ prev_reg) :
                      (sync_reg == level[i]);
  end

  // Pin level reaches the evaluation exactly two cycles later, once
  // both stages have run out of reset
  AST_SYNC_DELAY: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn, 2) && $past(aresetn) |->
    sync_level == $past(pin_in, 2))
    else $error("pin level not synchronised in two cycles");

endmodule : gic_pin_detect

/* core/gic_irq_config.sv */
// Pin interrupt configuration, pending flags and register slave
`timescale 1ns/1ps
module gic_irq_config
  import gic_pkg::*;
(
  input wire logic aclk,                      // System clock
  input wire logic aresetn,                   // Synchronous reset, low
  input wire logic [AXI_ADDR_W-1:0] s_awaddr, // Write address
  input wire logic [2:0] s_awprot,            // Write protection
  input wire logic s_awvalid,                 // Write address valid
  output logic s_awready,                     // Write address ready
  input wire logic [AXI_DATA_W-1:0] s_wdata,  // Write data
  input wire logic [3:0] s_wstrb,             // Write byte lanes
  input wire logic s_wvalid,                  // Write data valid
  output logic s_wready,                      // Write data ready
  output logic [1:0] s_bresp,                 // Write response
  output logic s_bvalid,                      // Write response valid
  input wire logic s_bready,                  // Write response ready
  input wire logic [AXI_ADDR_W-1:0] s_araddr, // Read address
  input wire logic [2:0] s_arprot,            // Read protection
  input wire logic s_arvalid,                 // Read address valid
  output logic s_arready,                     // Read address ready
  output logic [AXI_DATA_W-1:0] s_rdata,      // Read data
  output logic [1:0] s_rresp,                 // Read response
  output logic s_rvalid,                      // Read data valid
  input wire logic s_rready,                  // Read data ready
  input wire logic [PIN_COUNT-1:0] pin_in,    // Asynchronous pins
  output logic irq,                           // Level interrupt, high
  output logic carrier_detect_input_n         // Carrier detect, low
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  gic_cfg_type cfg_reg, cfg_next;               // Configuration
  logic [PIN_COUNT-1:0] pending_reg, pending_next; // Pending flags
  logic irq_reg, irq_next;                      // Interrupt output
  logic carrier_reg, carrier_next;              // Carrier output
  gic_wreq_type wreq_reg, wreq_next;            // Held write
  logic aw_have_reg, aw_have_next;              // Address held
  logic w_have_reg, w_have_next;                // Data held
  logic awready_reg, awready_next;              // Address ready
  logic wready_reg, wready_next;                // Data ready
  logic bvalid_reg, bvalid_next;                // Response valid
  logic [1:0] bresp_reg, bresp_next;            // Response code
  logic arready_reg, arready_next;              // Read ready
  logic rvalid_reg, rvalid_next;                // Read valid
  logic [1:0] rresp_reg, rresp_next;            // Read code
  logic [AXI_DATA_W-1:0] rdata_reg, rdata_next; // Read data
  logic wr_fire;                                // Write executes
  logic [PIN_COUNT-1:0] clr_vec;                // Bits to clear
  logic [PIN_COUNT-1:0] hit_vec;                // Enabled matches
  logic [PIN_COUNT-1:0] sync_level;             // Synchronised pins
  logic [PIN_COUNT-1:0] prev_level;             // Previous levels
  logic [PIN_COUNT-1:0] match;                  // Trigger matches
  logic [IDX_W-1:0] rd_idx;                     // Read word index

  // Index slices used by the decoders
  localparam logic [IDX_W-1:0] I_LO_PEND = IDX_LO_PENDING[IDX_W-1:0];
  localparam logic [IDX_W-1:0] I_HI_PEND = IDX_HI_PENDING[IDX_W-1:0];
  localparam logic [IDX_W-1:0] I_LO_ALLOW = IDX_LO_ALLOW[IDX_W-1:0];
  localparam logic [IDX_W-1:0] I_HI_ALLOW = IDX_HI_ALLOW[IDX_W-1:0];
  localparam logic [IDX_W-1:0] I_LO_TRIG = IDX_LO_TRIG[IDX_W-1:0];
  localparam logic [IDX_W-1:0] I_HI_TRIG = IDX_HI_TRIG[IDX_W-1:0];
  localparam logic [IDX_W-1:0] I_LO_LEVEL = IDX_LO_LEVEL[IDX_W-1:0];
  localparam logic [IDX_W-1:0] I_HI_LEVEL = IDX_HI_LEVEL[IDX_W-1:0];
  localparam logic [IDX_W-1:0] I_LO_CLEAR = IDX_LO_CLEAR[IDX_W-1:0];
  localparam logic [IDX_W-1:0] I_HI_CLEAR = IDX_HI_CLEAR[IDX_W-1:0];

  // Merge the two low byte lanes into a half register
  function automatic logic [HALF_W-1:0] merge_half(
    input logic [HALF_W-1:0] old_val,
    input logic [AXI_DATA_W-1:0] data,
    input logic [3:0] strb);
    logic [HALF_W-1:0] res;
    res = old_val;
    if (strb[0])
      res[7:0] = data[7:0];
    if (strb[1])
      res[15:8] = data[15:8];
    return res;
  endfunction : merge_half

  // ****************************************************************
  // Pin detection
  // ****************************************************************
  gic_pin_detect #(
    .WIDTH(PIN_COUNT)
  ) u_detect (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(pin_in),
    .trigger(cfg_reg.trigger),
    .level(cfg_reg.level),
    .sync_level(sync_level),
    .prev_level(prev_level),
    .match(match)
  );

  // Only enabled pins count their matches
  assign hit_vec = cfg_reg.allow & match;

  // ****************************************************************
  // Write channel
  // ****************************************************************
  assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;

  // Takes address and data in either order, answers after both
  always_comb
  begin
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    wreq_next = wreq_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    // Address taken
    if (s_awvalid && awready_reg)
    begin
      aw_have_next = 1'b1;
      wreq_next.idx = s_awaddr[AXI_ADDR_W-1:IDX_LSB];
    end
    // Data taken
    if (s_wvalid && wready_reg)
    begin
      w_have_next = 1'b1;
      wreq_next.data = s_wdata;
      wreq_next.strb = s_wstrb;
    end
    // Write executes, response raised
    if (wr_fire)
    begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      case (wreq_reg.idx)
        I_LO_PEND, I_HI_PEND, I_LO_ALLOW, I_HI_ALLOW, I_LO_TRIG,
        I_HI_TRIG, I_LO_LEVEL, I_HI_LEVEL, I_LO_CLEAR, I_HI_CLEAR:
          bresp_next = RESP_OKAY;
        default:
          bresp_next = RESP_SLVERR;
      endcase
    end
    // Response accepted
    else if (bvalid_reg && s_bready)
    begin
      bvalid_next = 1'b0;
    end
    awready_next = !aw_have_next;
    wready_next = !w_have_next;
  end

  // ****************************************************************
  // Configuration and clear decode
  // ****************************************************************
  always_comb
  begin
    cfg_next = cfg_reg;
    clr_vec = WORD_ZERO;
    if (wr_fire)
    begin
      case (wreq_reg.idx)
        // Lower enables
        I_LO_ALLOW: cfg_next.allow[15:0] = merge_half(
          cfg_reg.allow[15:0], wreq_reg.data, wreq_reg.strb);
        // Upper enables
        I_HI_ALLOW: cfg_next.allow[31:16] = merge_half(
          cfg_reg.allow[31:16], wreq_reg.data, wreq_reg.strb);
        // Lower trigger select
        I_LO_TRIG: cfg_next.trigger[15:0] = merge_half(
          cfg_reg.trigger[15:0], wreq_reg.data, wreq_reg.strb);
        // Upper trigger select
        I_HI_TRIG: cfg_next.trigger[31:16] = merge_half(
          cfg_reg.trigger[31:16], wreq_reg.data, wreq_reg.strb);
        // Lower active level
        I_LO_LEVEL: cfg_next.level[15:0] = merge_half(
          cfg_reg.level[15:0], wreq_reg.data, wreq_reg.strb);
        // Upper active level
        I_HI_LEVEL: cfg_next.level[31:16] = merge_half(
          cfg_reg.level[31:16], wreq_reg.data, wreq_reg.strb);
        // Write one to clear pending flags
        I_LO_CLEAR: clr_vec[15:0] = merge_half(
          HALF_RESET, wreq_reg.data, wreq_reg.strb);
        I_HI_CLEAR: clr_vec[31:16] = merge_half(
          HALF_RESET, wreq_reg.data, wreq_reg.strb);
        // Status and unmapped writes change nothing
        default: cfg_next = cfg_reg;
      endcase
    end
  end

  // ****************************************************************
  // Pending flags, interrupt and carrier detect
  // ****************************************************************
  always_comb
  begin
    // New match wins over a clear in the same cycle
    pending_next = (pending_reg & ~clr_vec) | hit_vec;
    // Interrupt while an enabled flag stands
    irq_next = |(pending_reg & cfg_reg.allow);
    // Pin fifteen always feeds carrier detect
    carrier_next = sync_level[CARRIER_PIN];
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  assign rd_idx = s_araddr[AXI_ADDR_W-1:IDX_LSB];

  // One read at a time, answered the cycle after the address
  always_comb
  begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_arvalid && arready_reg)
    begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      rdata_next = WORD_ZERO;
      case (rd_idx)
        I_LO_PEND: rdata_next[15:0] = pending_reg[15:0];
        I_HI_PEND: rdata_next[15:0] = pending_reg[31:16];
        I_LO_ALLOW: rdata_next[15:0] = cfg_reg.allow[15:0];
        I_HI_ALLOW: rdata_next[15:0] = cfg_reg.allow[31:16];
        I_LO_TRIG: rdata_next[15:0] = cfg_reg.trigger[15:0];
        I_HI_TRIG: rdata_next[15:0] = cfg_reg.trigger[31:16];
        I_LO_LEVEL: rdata_next[15:0] = cfg_reg.level[15:0];
        I_HI_LEVEL: rdata_next[15:0] = cfg_reg.level[31:16];
        // Clear registers read as zero
        I_LO_CLEAR, I_HI_CLEAR: rdata_next = WORD_ZERO;
        default: rresp_next = RESP_SLVERR;
      endcase
    end
    else if (rvalid_reg && s_rready)
    begin
      rvalid_next = 1'b0;
    end
    arready_next = !rvalid_next;
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_reg <= '{allow: WORD_ZERO, trigger: WORD_ZERO,
                   level: WORD_ZERO};
      pending_reg <= WORD_ZERO;
      irq_reg <= 1'b0;
      carrier_reg <= 1'b0;
      wreq_reg <= '{idx: '0, data: WORD_ZERO, strb: 4'h0};
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= WORD_ZERO;
    end
    else
    begin
      cfg_reg <= cfg_next;
      pending_reg <= pending_next;
      irq_reg <= irq_next;
      carrier_reg <= carrier_next;
      wreq_reg <= wreq_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  // Outputs straight from flops
  assign s_awready = awready_reg;
  assign s_wready = wready_reg;
  assign s_bvalid = bvalid_reg;
  assign s_bresp = bresp_reg;
  assign s_arready = arready_reg;
  assign s_rvalid = rvalid_reg;
  assign s_rresp = rresp_reg;
  assign s_rdata = rdata_reg;
  assign irq = irq_reg;
  assign carrier_detect_input_n = carrier_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_DISABLED_NO_SET: assert property (
    ##1 (pending_reg & ~$past(pending_reg) & ~$past(cfg_reg.allow)) == '0)
    else $error("disabled pin raised its pending flag");

  AST_EDGE_SETS: assert property (
    ##1 ((pending_reg & $past(cfg_reg.allow & cfg_reg.trigger &
      (sync_level ^ prev_level))) == $past(cfg_reg.allow &
      cfg_reg.trigger & (sync_level ^ prev_level))))
    else $error("edge on enabled pin did not set pending");

  AST_LEVEL_SETS: assert property (
    ##1 ((pending_reg & $past(cfg_reg.allow & ~cfg_reg.trigger &
      ~(sync_level ^ cfg_reg.level))) == $past(cfg_reg.allow &
      ~cfg_reg.trigger & ~(sync_level ^ cfg_reg.level))))
    else $error("active level on enabled pin did not set pending");

  AST_EDGE_IGNORES_LEVEL: assert property (
    ##1 (pending_reg & ~$past(pending_reg) & $past(cfg_reg.trigger &
      ~(sync_level ^ prev_level))) == '0)
    else $error("edge mode pin set pending without a change");

  AST_CLEAR: assert property (
    ##1 (pending_reg & $past(clr_vec & ~hit_vec)) == '0)
    else $error("write one did not clear pending flag");

  AST_SET_WINS: assert property (
    ##1 (pending_reg & $past(hit_vec)) == $past(hit_vec))
    else $error("clear beat a simultaneous match");

  AST_IRQ_FOLLOWS: assert property (
    (|(pending_reg & cfg_reg.allow)) [*2] |-> irq)
    else $error("interrupt low with enabled pending flag");

  AST_CARRIER: assert property (
    ##1 carrier_detect_input_n == $past(sync_level[CARRIER_PIN]))
    else $error("carrier detect does not follow pin fifteen");

  AST_TRIG_WRITE: assert property (
    (wr_fire && wreq_reg.idx == I_LO_TRIG && wreq_reg.strb[1:0] == 2'h3)
    |=> cfg_reg.trigger[15:0] == $past(wreq_reg.data[15:0]))
    else $error("trigger select write not stored");

  AST_BVALID_HOLD: assert property (
    s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped before accept");

  COV_EDGE: cover property (|(hit_vec & cfg_reg.trigger));
  COV_LEVEL: cover property (|(hit_vec & ~cfg_reg.trigger));
  COV_CLEAR: cover property (|(clr_vec & pending_reg));
  COV_IRQ: cover property ($rose(irq));

endmodule : gic_irq_config

/* dv/gic_pin_model.sv */
// Model of the external signals that drive the general-purpose pins
`timescale 1ns/1ps
module gic_pin_model
  import gic_pkg::*;
(
  input wire logic aclk,                 // System clock
  input wire logic slow,                 // Answer one cycle later
  input wire logic [PIN_COUNT-1:0] want, // Levels asked by the bench
  output logic [PIN_COUNT-1:0] pins      // Levels seen on the pins
);
  logic [PIN_COUNT-1:0] stage_reg; // Extra delay stage for slow mode

  // Pins move right after an edge, never aligned to the block's sampling
  always_ff @(posedge aclk)
  begin
    stage_reg <= want;
    pins <= slow ? stage_reg : want;
  end
endmodule : gic_pin_model

/* dv/testbench.sv */
// Self-checking bench for the pin interrupt configuration block
`timescale 1ns/1ps
module testbench;
  import gic_pkg::*;
  logic aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready;
  logic s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
  logic irq, carrier_detect_input_n, slow;
  logic [AXI_ADDR_W-1:0] s_awaddr, s_araddr;
  logic [2:0] s_awprot, s_arprot;
  logic [AXI_DATA_W-1:0] s_wdata, s_rdata, rd;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, rs;
  logic [PIN_COUNT-1:0] pin_in, want;
  logic [31:0] idx_tab [6]; // Configuration registers
  int n_fail = 0; // Mismatches
  int samples_checked = 0; // Comparisons

  gic_irq_config i_gic_irq_config (.aclk, .aresetn, .s_awaddr, .s_awprot,
    .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
    .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arprot, .s_arvalid,
    .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .pin_in, .irq,
    .carrier_detect_input_n);
  gic_pin_model i_gic_pin_model (.aclk, .slow, .want, .pins(pin_in));

  // ****************************************************************
  // Bus and check tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [11:0] ba(input logic [31:0] idx);
    return {idx[9:0], 2'b00};
  endfunction : ba

  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [31:0] idx, input logic [31:0] d);
    s_awaddr <= ba(idx);
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end
    while (!s_bvalid);
    rs = s_bresp;
    s_bready <= 1'b0;
    // Let an edge pass so a following call never re-raises bready at once
    @(posedge aclk);
  endtask : wr

  task automatic rd_reg(input logic [31:0] idx);
    s_araddr <= ba(idx);
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 1'b0;
    end
    while (!s_rvalid);
    rd = s_rdata;
    rs = s_rresp;
    s_rready <= 1'b0;
    // Let an edge pass so a following call never re-raises rready at once
    @(posedge aclk);
  endtask : rd_reg

  task automatic rchk(input string what, input logic [31:0] idx, exp);
    rd_reg(idx);
    chk(what, exp, rd);
  endtask : rchk

  // Pin change, then enough cycles for sync, flag and interrupt
  task automatic pins(input logic [31:0] v);
    want <= v;
    repeat (8) @(posedge aclk);
  endtask : pins

  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // ****************************************************************
  // Clock, watchdog and test sequence
  // ****************************************************************
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Cut a hang well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (5000) @(posedge aclk);
    n_fail++;
    test_done();
  end

  initial
  begin
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_araddr, s_awprot, s_arprot, s_wdata} = '0;
    s_wstrb = 4'hF;
    want = '0;
    slow = 1'b0;
    aresetn = 1'b0;
    idx_tab = '{IDX_LO_ALLOW, IDX_HI_ALLOW, IDX_LO_TRIG, IDX_HI_TRIG,
      IDX_LO_LEVEL, IDX_HI_LEVEL};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    foreach (idx_tab[i])
    begin
      rchk("reset", idx_tab[i], WORD_ZERO);
      wr(idx_tab[i], 32'hFFFF_5A00 + 32'(i));
      chk("bresp", RESP_OKAY, rs);
      rchk("rw", idx_tab[i], 32'h0000_5A00 + 32'(i));
      wr(idx_tab[i], WORD_ZERO);
    end
    // Enables written above caught low pins in level-low mode
    rchk("pend", IDX_LO_PENDING, 32'h0000_5A00);
    rchk("pend", IDX_HI_PENDING, 32'h0000_5A01);
    wr(IDX_LO_CLEAR, 32'h0000_FFFF);
    wr(IDX_HI_CLEAR, 32'h0000_FFFF);
    // Unmapped word answers with an error and reads zero
    wr(32'h0B00_01FC, 32'h0000_FFFF);
    chk("bresp", RESP_SLVERR, rs);
    rd_reg(32'h0B00_01FC);
    chk("rresp", RESP_SLVERR, rs);
    chk("rdata", WORD_ZERO, rd);
    // Low pins: 0 and 3 edge, 1 level low, 2 level high
    wr(IDX_LO_TRIG, 32'h0000_0009);
    wr(IDX_LO_LEVEL, 32'h0000_000C);
    wr(IDX_LO_ALLOW, 32'h0000_000F);
    pins(32'h0000_0000);
    rchk("pend", IDX_LO_PENDING, 32'h0000_0002);
    chk("irq", 32'h1, irq);
    wr(IDX_LO_CLEAR, WORD_ZERO);
    rchk("pend", IDX_LO_PENDING, 32'h0000_0002);
    pins(32'h0000_0002);
    wr(IDX_LO_CLEAR, 32'h0000_0002);
    rchk("pend", IDX_LO_PENDING, WORD_ZERO);
    chk("irq", 32'h0, irq);
    pins(32'h0000_000F);
    rchk("pend", IDX_LO_PENDING, 32'h0000_000D);
    wr(IDX_LO_CLEAR, 32'h0000_000F);
    rchk("pend", IDX_LO_PENDING, 32'h0000_0004);
    pins(32'h0000_0002);
    rchk("pend", IDX_LO_PENDING, 32'h0000_000D);
    wr(IDX_LO_CLEAR, 32'h0000_000F);
    rchk("pend", IDX_LO_PENDING, WORD_ZERO);
    // High pins with a slow far side: 31 edge, 16 level low
    slow <= 1'b1;
    wr(IDX_HI_TRIG, 32'h0000_8000);
    pins(32'h8000_0002);
    rchk("pend", IDX_HI_PENDING, WORD_ZERO);
    wr(IDX_HI_ALLOW, 32'h0000_0001);
    pins(32'h0000_0002);
    rchk("pend", IDX_HI_PENDING, 32'h0000_0001);
    wr(IDX_HI_ALLOW, 32'h0000_8001);
    pins(32'h8000_0002);
    rchk("pend", IDX_HI_PENDING, 32'h0000_8001);
    pins(32'h8000_8002);
    chk("carrier", 32'h1, carrier_detect_input_n);
    pins(32'h8000_0002);
    chk("carrier", 32'h0, carrier_detect_input_n);
    test_done();
  end
endmodule : testbench
